// ### hw/encoder_param_pkg.sv
/*
  package for the encoder acyclic parameter bank: parameter numbers,
  array sizes, fixed read-only values, reset values and the request and
  answer carriers.
  assumes one synchronous system clock shared with the request source.
*/
package encoder_param_pkg;

  // parameter numbers and record index as seen on the request port
  localparam logic [15:0] PAR_TELEGRAM = 16'h039A; // telegram_select
  localparam logic [15:0] PAR_LIFESIGN = 16'h039D; // lifesign_tolerance
  localparam logic [15:0] PAR_DEV_ID = 16'h03C4; // device_ident_array
  localparam logic [15:0] PAR_PROF_ID = 16'h03C5; // profile_ident_array
  localparam logic [15:0] PAR_NV_STORE = 16'h03CB; // nv_store_trigger
  localparam logic [15:0] PAR_ACCESS = 16'h03CE; // access_capability_array
  localparam logic [15:0] PAR_DO_ID = 16'h03CF; // drive_object_ident_array
  localparam logic [15:0] PAR_SENSOR = 16'h03D3; // sensor_format_array
  localparam logic [15:0] PAR_LIST = 16'h03D4; // param_number_list
  localparam logic [15:0] PAR_IM_RECORD = 16'hAFF0; // ident_maint_record
  localparam logic [15:0] PAR_PRESET = 16'hFDE8; // preset_value
  localparam logic [15:0] PAR_OPSTAT = 16'hFDE9; // operating_status_array

  // last valid subindex of each array
  localparam logic [7:0] DEV_ID_LAST = 8'h05;
  localparam logic [7:0] PROF_ID_LAST = 8'h01;
  localparam logic [7:0] ACCESS_LAST = 8'h02;
  localparam logic [7:0] DO_ID_LAST = 8'h07;
  localparam logic [7:0] SENSOR_LAST = 8'h05;
  localparam logic [7:0] LIST_LAST = 8'h09;
  localparam logic [7:0] OPSTAT_LAST = 8'h0B;
  localparam logic [7:0] IM_WORD_LAST = 8'h0F; // 64-byte record, 16 words
  localparam logic [15:0] IM_MODULE_ZERO = 16'h0000;

  // fixed read-only contents
  localparam logic [15:0] UNIT_TYPE = 16'h0001;
  localparam logic [15:0] DO_COUNT = 16'h0001;
  localparam logic [15:0] DO_TYPE = 16'h0001;
  localparam logic [15:0] DO_CLASS = 16'h0005;
  localparam logic [15:0] DO_SUBCLASS = 16'h4000;
  localparam logic [15:0] DO_OBJECT_ID = 16'h0001;
  localparam logic [7:0] PROFILE_NUMBER = 8'h3D;
  localparam logic [7:0] PROFILE_V31 = 8'h1F; // 31 decimal
  localparam logic [7:0] PROFILE_V41 = 8'h29; // 41 decimal
  localparam logic [15:0] ACC_MAX_BLOCK = 16'h0046; // 70 decimal
  localparam logic [15:0] ACC_MAX_PARAMS = 16'h0001;
  localparam logic [15:0] ACC_LATENCY = 16'h0000;
  localparam logic [31:0] SENS_HEADER = 32'h0000_5011;
  localparam logic [31:0] SENS_TYPE = 32'h0000_8000;
  localparam logic [31:0] SENS_RESOLUTION = 32'h0001_0000; // 65,536
  localparam logic [31:0] SENS_SHIFT = 32'h0000_0000;
  localparam logic [31:0] DET_RES_NONE = 32'h0000_0000;
  localparam logic [31:0] DET_RES_4K = 32'h0000_1000;
  localparam logic [31:0] DET_RES_16K = 32'h0000_4000;
  localparam logic [31:0] OPSTAT_HEADER = 32'h000C_0101;
  localparam logic [31:0] SUPPORTED_FAULTS = 32'h0000_0031;
  localparam logic [31:0] WARNINGS_NONE = 32'h0000_0000;
  localparam logic [31:0] ENC_PROFILE_VER = 32'h0000_0401;
  localparam logic [31:0] OP_TIME_NONE = 32'hFFFF_FFFF;

  // life-sign tolerance limits and values
  localparam logic [31:0] LS_MIN = 32'h0000_0001;
  localparam logic [31:0] LS_OFF = 32'h0000_00FF; // monitoring disabled
  localparam logic [7:0] LS_FIXED = 8'h01; // tolerance outside compat mode
  localparam logic [31:0] NV_MAX = 32'h0000_0001;
  localparam int STW_PRESET_BIT = 12; // preset request bit of control word

  // reset values
  localparam logic [15:0] LS_RESET = 16'h0001;
  localparam logic [31:0] PRESET_RESET = 32'h0000_0000;

  // acyclic request: index, subindex, record module, write data
  typedef struct packed {
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [15:0] module_nr;
    logic [31:0] wdata;
  } param_req_t;

  // acyclic answer: error flag and read data
  typedef struct packed {
    logic err;
    logic [31:0] data;
  } param_rsp_t;

endpackage

// ### hw/encoder_acyclic_parameter_bank.sv
/*
  acyclic parameter bank of the networked resolver encoder: answers
  parameter and record requests, holds the writable parameters and hands
  the life-sign tolerance, store trigger and preset event to the core.
  assumes requests, live values and the cyclic control word come from
  logic on sys_clk_i; one request per cycle at most, answer next cycle.
*/
`timescale 1ns/100ps
module encoder_acyclic_parameter_bank #(
  parameter logic [15:0] VENDOR_ID = 16'h0ABC, // arbitrary value
  parameter logic [15:0] SW_VERSION = 16'h0076,
  parameter logic [15:0] SW_YEAR = 16'h07E2,
  parameter logic [15:0] SW_DAY_MONTH = 16'h0065,
  parameter logic [47:0] IM_HEADER = 48'h0000_0000_0000,
  parameter logic [47:0] IM_VENDOR = 48'h0000_0000_0ABC, // arbitrary value
  parameter logic [159:0] IM_ORDER = 160'h0, // arbitrary value
  parameter logic [127:0] IM_SERIAL = 128'h0, // arbitrary value
  parameter logic [15:0] IM_HW_REV = 16'h0001,
  parameter logic [31:0] IM_SW_REV = 32'h0000_0001,
  parameter logic [79:0] IM_TAIL = 80'h0 // five trailing 16-bit fields
)(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i, // one-cycle request strobe
  input wire encoder_param_pkg::param_req_t req_i,
  input wire logic compat_mode_i, // older profile behaviour
  input wire logic profile_v41_i, // configured profile version
  input wire logic [15:0] telegram_i, // telegram number in use
  input wire logic [1:0] turns_sel_i, // 0 single, 1 4096, 2 16384 turns
  input wire logic [31:0] op_status_i, // operating status bits
  input wire logic [31:0] faults_i, // live fault bits
  input wire logic [31:0] xist1_offset_i, // primary_position_word offset
  input wire logic [31:0] units_per_rev_i, // units_per_revolution
  input wire logic [31:0] total_range_i, // total_measurement_range
  input wire logic [31:0] velocity_unit_i,
  input wire logic [15:0] sensor_control_word_i,
  input wire logic nv_store_done_i, // one-cycle save completion
  output logic rsp_valid_o,
  output encoder_param_pkg::param_rsp_t rsp_o,
  output logic [7:0] lifesign_limit_o, // tolerated life-sign faults
  output logic lifesign_monitor_en_o,
  output logic nv_store_req_o, // level while a save is pending
  output logic [31:0] preset_value_o,
  output logic preset_apply_o // one-cycle pulse on preset request
);
  import encoder_param_pkg::*;

  // whole identity record, first byte in the top bits
  localparam logic [511:0] IM_RECORD =
    {IM_HEADER, IM_VENDOR, IM_ORDER, IM_SERIAL, IM_HW_REV, IM_SW_REV, IM_TAIL};

  logic rsp_valid_q, rsp_valid_d; // answer strobe
  param_rsp_t rsp_q, rsp_d; // answer contents, held until next answer
  logic [15:0] ls_q, ls_d; // stored life-sign tolerance
  logic nv_q, nv_d; // store trigger
  logic [31:0] preset_q, preset_d; // stored preset value
  logic stw12_q, stw12_d; // last preset request bit
  logic apply_q, apply_d; // preset apply pulse
  logic [7:0] ls_lim_q, ls_lim_d; // effective tolerance
  logic ls_en_q, ls_en_d; // monitoring enable
  logic hit; // index and subindex exist
  logic rw_ok; // index may be written
  logic [31:0] rdata; // read value of addressed entry
  logic wr_ok; // write accepted

  // pick one 32-bit word of the identity record
  function automatic logic [31:0] im_word(input logic [7:0] sub);
    logic [3:0] w;
    w = sub[3:0];
    im_word = IM_RECORD[511 - 32 * w -: 32];
  endfunction

  // widen a 16-bit entry into the answer word
  function automatic logic [31:0] w16(input logic [15:0] v);
    w16 = {16'h0000, v};
  endfunction

  // read decode: which entries exist and what they hold
  always_comb
  begin
    hit = 1'b1;
    rw_ok = 1'b0;
    rdata = 32'h0000_0000;
    case (req_i.index)
      PAR_IM_RECORD:
      begin
        // only module zero and the 16 record words exist
        hit = (req_i.module_nr == IM_MODULE_ZERO) && (req_i.sub <= IM_WORD_LAST);
        rdata = im_word(req_i.sub);
      end
      PAR_TELEGRAM:
      begin
        hit = (req_i.sub == 8'h00);
        rdata = w16(telegram_i);
      end
      PAR_LIFESIGN:
      begin
        hit = (req_i.sub == 8'h00);
        rw_ok = 1'b1;
        rdata = w16(ls_q);
      end
      PAR_DEV_ID:
      begin
        hit = (req_i.sub <= DEV_ID_LAST);
        case (req_i.sub[2:0])
          3'h0: rdata = w16(VENDOR_ID);
          3'h1: rdata = w16(UNIT_TYPE);
          3'h2: rdata = w16(SW_VERSION);
          3'h3: rdata = w16(SW_YEAR);
          3'h4: rdata = w16(SW_DAY_MONTH);
          default: rdata = w16(DO_COUNT);
        endcase
      end
      PAR_PROF_ID:
      begin
        // octets sit in the low byte, upper bits read zero
        hit = (req_i.sub <= PROF_ID_LAST);
        if (req_i.sub[0] == 1'b0)
        begin
          rdata = {24'h00_0000, PROFILE_NUMBER};
        end
        else
        begin
          rdata = {24'h00_0000, (profile_v41_i ? PROFILE_V41 : PROFILE_V31)};
        end
      end
      PAR_NV_STORE:
      begin
        hit = (req_i.sub == 8'h00);
        rw_ok = 1'b1;
        rdata = {31'h0000_0000, nv_q};
      end
      PAR_ACCESS:
      begin
        hit = (req_i.sub <= ACCESS_LAST);
        case (req_i.sub[1:0])
          2'h0: rdata = w16(ACC_MAX_BLOCK);
          2'h1: rdata = w16(ACC_MAX_PARAMS);
          default: rdata = w16(ACC_LATENCY);
        endcase
      end
      PAR_DO_ID:
      begin
        hit = (req_i.sub <= DO_ID_LAST);
        case (req_i.sub[2:0])
          3'h0: rdata = w16(VENDOR_ID);
          3'h1: rdata = w16(DO_TYPE);
          3'h2: rdata = w16(SW_VERSION);
          3'h3: rdata = w16(SW_YEAR);
          3'h4: rdata = w16(SW_DAY_MONTH);
          3'h5: rdata = w16(DO_CLASS);
          3'h6: rdata = w16(DO_SUBCLASS);
          default: rdata = w16(DO_OBJECT_ID);
        endcase
      end
      PAR_SENSOR:
      begin
        hit = (req_i.sub <= SENSOR_LAST);
        case (req_i.sub[2:0])
          3'h0: rdata = SENS_HEADER;
          3'h1: rdata = SENS_TYPE;
          3'h2: rdata = SENS_RESOLUTION;
          3'h3: rdata = SENS_SHIFT;
          3'h4: rdata = SENS_SHIFT;
          default:
          begin
            // determinable resolution follows the turn count
            case (turns_sel_i)
              2'h1: rdata = DET_RES_4K;
              2'h2: rdata = DET_RES_16K;
              default: rdata = DET_RES_NONE;
            endcase
          end
        endcase
      end
      PAR_LIST:
      begin
        hit = (req_i.sub <= LIST_LAST);
        case (req_i.sub[3:0])
          4'h0: rdata = w16(PAR_TELEGRAM);
          4'h1: rdata = w16(PAR_LIFESIGN);
          4'h2: rdata = w16(PAR_DEV_ID);
          4'h3: rdata = w16(PAR_PROF_ID);
          4'h4: rdata = w16(PAR_NV_STORE);
          4'h5: rdata = w16(PAR_ACCESS);
          4'h6: rdata = w16(PAR_DO_ID);
          4'h7: rdata = w16(PAR_SENSOR);
          4'h8: rdata = w16(PAR_PRESET);
          default: rdata = w16(PAR_OPSTAT);
        endcase
      end
      PAR_PRESET:
      begin
        hit = (req_i.sub == 8'h00);
        rw_ok = 1'b1;
        rdata = preset_q;
      end
      PAR_OPSTAT:
      begin
        hit = (req_i.sub <= OPSTAT_LAST);
        case (req_i.sub[3:0])
          4'h0: rdata = OPSTAT_HEADER;
          4'h1: rdata = op_status_i;
          4'h2: rdata = faults_i & SUPPORTED_FAULTS;
          4'h3: rdata = SUPPORTED_FAULTS;
          4'h4: rdata = WARNINGS_NONE;
          4'h5: rdata = WARNINGS_NONE;
          4'h6: rdata = ENC_PROFILE_VER;
          4'h7: rdata = OP_TIME_NONE;
          4'h8: rdata = xist1_offset_i;
          4'h9: rdata = units_per_rev_i;
          4'hA: rdata = total_range_i;
          default: rdata = velocity_unit_i;
        endcase
      end
      default: hit = 1'b0;
    endcase
  end

  // write check: range of each writable parameter
  always_comb
  begin
    wr_ok = 1'b0;
    case (req_i.index)
      PAR_LIFESIGN: wr_ok = (req_i.wdata >= LS_MIN) && (req_i.wdata <= LS_OFF);
      PAR_NV_STORE: wr_ok = (req_i.wdata <= NV_MAX);
      PAR_PRESET: wr_ok = (req_i.wdata < total_range_i);
      default: wr_ok = 1'b0;
    endcase
    wr_ok = wr_ok && hit && rw_ok;
  end

  // next state: answer, stored parameters, preset edge, tolerance
  always_comb
  begin
    rsp_valid_d = req_valid_i;
    rsp_d = rsp_q;
    ls_d = ls_q;
    nv_d = nv_q;
    preset_d = preset_q;
    // save completion clears the trigger; a new rising write below wins
    if (nv_store_done_i)
    begin
      nv_d = 1'b0;
    end
    if (req_valid_i)
    begin
      if (req_i.write)
      begin
        // failed writes leave every stored value untouched
        rsp_d.err = !wr_ok;
        rsp_d.data = 32'h0000_0000;
        if (wr_ok)
        begin
          case (req_i.index)
            PAR_LIFESIGN: ls_d = req_i.wdata[15:0];
            PAR_NV_STORE:
            begin
              // only a 0 to 1 move starts a save
              if (req_i.wdata[0] && !nv_q)
              begin
                nv_d = 1'b1;
              end
            end
            default: preset_d = req_i.wdata;
          endcase
        end
      end
      else
      begin
        rsp_d.err = !hit;
        rsp_d.data = hit ? rdata : 32'h0000_0000;
      end
    end
    // preset is applied only on the cyclic request edge
    stw12_d = sensor_control_word_i[STW_PRESET_BIT];
    apply_d = sensor_control_word_i[STW_PRESET_BIT] && !stw12_q;
    // outside compat mode one fault is tolerated, always monitored
    if (compat_mode_i)
    begin
      ls_lim_d = ls_q[7:0];
      ls_en_d = (ls_q != LS_OFF[15:0]);
    end
    else
    begin
      ls_lim_d = LS_FIXED;
      ls_en_d = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      ls_q <= LS_RESET;
      nv_q <= 1'b0;
      preset_q <= PRESET_RESET;
      stw12_q <= 1'b0;
      apply_q <= 1'b0;
      ls_lim_q <= LS_FIXED;
      ls_en_q <= 1'b1;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
      ls_q <= ls_d;
      nv_q <= nv_d;
      preset_q <= preset_d;
      stw12_q <= stw12_d;
      apply_q <= apply_d;
      ls_lim_q <= ls_lim_d;
      ls_en_q <= ls_en_d;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_o = rsp_q;
  assign lifesign_limit_o = ls_lim_q;
  assign lifesign_monitor_en_o = ls_en_q;
  assign nv_store_req_o = nv_q;
  assign preset_value_o = preset_q;
  assign preset_apply_o = apply_q;

  // checks on the answer path and stored state
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_answer_next_cycle: assert property (req_valid_i |=> rsp_valid_o)
    else $error("answer did not follow request by one cycle");
  a_no_idle_answer: assert property (!req_valid_i |=> !rsp_valid_o)
    else $error("answer without request");
  a_record_ro: assert property (req_valid_i && req_i.write && req_i.index == PAR_IM_RECORD |=> rsp_o.err)
    else $error("write to identity record not refused");
  a_telegram_ro: assert property (req_valid_i && req_i.write && req_i.index == PAR_TELEGRAM |=> rsp_o.err)
    else $error("write to telegram selection not refused");
  a_ls_bad_write: assert property (req_valid_i && req_i.write && req_i.index == PAR_LIFESIGN && req_i.sub == 8'h00 && req_i.wdata == 32'h0000_0000 |=> rsp_o.err && $stable(ls_q))
    else $error("zero tolerance accepted");
  a_ls_fixed: assert property (!compat_mode_i |=> lifesign_limit_o == LS_FIXED && lifesign_monitor_en_o)
    else $error("tolerance not fixed at one outside compat mode");
  a_nv_start: assert property (req_valid_i && req_i.write && req_i.index == PAR_NV_STORE && req_i.sub == 8'h00 && req_i.wdata == NV_MAX && !nv_q |=> nv_store_req_o)
    else $error("store trigger did not start");
  a_preset_edge: assert property ($rose(sensor_control_word_i[STW_PRESET_BIT]) |=> preset_apply_o ##1 !preset_apply_o || $rose(sensor_control_word_i[STW_PRESET_BIT]))
    else $error("preset apply pulse wrong");
  a_preset_no_apply: assert property (!$rose(sensor_control_word_i[STW_PRESET_BIT]) |=> !preset_apply_o)
    else $error("preset applied without request edge");
  a_unknown_err: assert property (req_valid_i && !req_i.write && !hit |=> rsp_o.err)
    else $error("unknown parameter not refused");

  c_preset_written: cover property (req_valid_i && req_i.write && req_i.index == PAR_PRESET ##1 rsp_valid_o && !rsp_o.err);
  c_nv_save: cover property (nv_store_req_o ##[1:20] !nv_store_req_o);
  c_record_read: cover property (req_valid_i && !req_i.write && req_i.index == PAR_IM_RECORD ##1 !rsp_o.err);
  c_preset_apply: cover property (preset_apply_o);

endmodule

// ### verif/ctrl_model.sv
/*
  controller model: issues acyclic requests one at a time and plays the
  nonvolatile memory that finishes a save SAVE_CYCLES after it starts.
  assumes the bank answers exactly one cycle after it takes a request.
*/
`timescale 1ns/100ps
module ctrl_model #(
  parameter int SAVE_CYCLES = 6
)(
  input wire logic sys_clk_i,
  input wire logic rsp_valid_i,
  input wire encoder_param_pkg::param_rsp_t rsp_i,
  input wire logic nv_store_req_i,
  output logic req_valid_o,
  output encoder_param_pkg::param_req_t req_o,
  output logic nv_store_done_o
);
  import encoder_param_pkg::*;
  int save_cnt; // cycles the pending save has run
  initial
  begin
    req_valid_o = 1'b0;
    req_o = '0;
    nv_store_done_o = 1'b0;
    save_cnt = 0;
  end
  // one-cycle strobe; fields inverted once released so stale values never pass
  task automatic xfer(input param_req_t r, output logic v, output param_rsp_t a);
    @(posedge sys_clk_i);
    req_valid_o <= 1'b1;
    req_o <= r;
    @(posedge sys_clk_i);
    req_valid_o <= 1'b0;
    req_o <= ~r;
    #1;
    v = rsp_valid_i;
    a = rsp_i;
  endtask
  // memory reports the finished save with a single pulse
  always @(posedge sys_clk_i)
  begin
    if (!nv_store_req_i)
    begin
      save_cnt <= 0;
      nv_store_done_o <= 1'b0;
    end
    else
    begin
      save_cnt <= save_cnt + 1;
      nv_store_done_o <= (save_cnt == SAVE_CYCLES);
    end
  end
endmodule

// ### verif/encoder_acyclic_parameter_bank_tb.sv
/*
  testbench for the acyclic parameter bank: fixed tables, live values,
  refusals, writable parameters, store trigger and preset apply.
  assumes ctrl_model plays the controller and the nonvolatile memory.
*/
`timescale 1ns/100ps
module encoder_acyclic_parameter_bank_tb;
  import encoder_param_pkg::*;
  localparam logic [15:0] VEND = 16'h0123; // arbitrary value
  localparam logic [15:0] SWV = 16'h0011;
  localparam logic [15:0] SWY = 16'h0022;
  localparam logic [15:0] SWD = 16'h0033;
  localparam logic [47:0] IMH = 48'hA1A2_A3A4_A5A6;
  localparam logic [47:0] IMV = 48'hB1B2_B3B4_B5B6; // arbitrary value
  localparam logic [79:0] IMT = 80'hC1C2_C3C4_C5C6_C7C8_C9CA;
  logic sys_clk_i, rst_i, req_valid_i, compat_mode_i, profile_v41_i, nv_store_done_i;
  param_req_t req_i;
  param_rsp_t rsp_o;
  logic rsp_valid_o, lifesign_monitor_en_o, nv_store_req_o, preset_apply_o;
  logic [15:0] telegram_i, sensor_control_word_i;
  logic [1:0] turns_sel_i;
  logic [31:0] op_status_i, faults_i, xist1_offset_i, units_per_rev_i;
  logic [31:0] total_range_i, velocity_unit_i, preset_value_o;
  logic [7:0] lifesign_limit_o;
  int n_errors, n_compared, cnt;
  // expected table contents, worked out by hand
  logic [31:0] dev_w[6] = '{VEND, 1, SWV, SWY, SWD, 1};
  logic [31:0] do_w[8] = '{VEND, 1, SWV, SWY, SWD, 32'h0005, 32'h4000, 1};
  logic [31:0] sens_w[5] = '{32'h5011, 32'h8000, 32'h0001_0000, 0, 0};
  logic [31:0] det_w[4] = '{0, 32'h1000, 32'h4000, 0};
  logic [31:0] acc_w[3] = '{32'h0046, 1, 0};
  logic [31:0] tg_w[5] = '{81, 82, 83, 84, 860};
  logic [15:0] list_w[10] = '{16'h039A, 16'h039D, 16'h03C4, 16'h03C5, 16'h03CB,
    16'h03CE, 16'h03CF, 16'h03D3, 16'hFDE8, 16'hFDE9};
  logic [31:0] ops_w[12] = '{32'h000C_0101, 32'h0000_0022, 32'h0000_0031, 32'h0000_0031,
    0, 0, 32'h0000_0401, 32'hFFFF_FFFF, 32'h1234_5678, 32'h0001_0000, 32'h0000_0064, 3};
  // refused accesses: write, index, subindex, record module
  logic [40:0] bad_w[10] = '{{1'b0, 16'h0400, 8'h0, 16'h0}, {1'b0, PAR_DEV_ID, 8'h6, 16'h0},
    {1'b0, PAR_OPSTAT, 8'hC, 16'h0}, {1'b0, PAR_LIST, 8'hA, 16'h0},
    {1'b1, PAR_TELEGRAM, 8'h0, 16'h0}, {1'b1, PAR_DEV_ID, 8'h0, 16'h0},
    {1'b1, PAR_OPSTAT, 8'h0, 16'h0}, {1'b1, PAR_LIST, 8'h0, 16'h0},
    {1'b0, PAR_IM_RECORD, 8'h0, 16'h1}, {1'b1, PAR_IM_RECORD, 8'h0, 16'h0}};

  encoder_acyclic_parameter_bank #(.VENDOR_ID(VEND), .SW_VERSION(SWV), .SW_YEAR(SWY),
    .SW_DAY_MONTH(SWD), .IM_HEADER(IMH), .IM_VENDOR(IMV), .IM_TAIL(IMT)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .compat_mode_i(compat_mode_i), .profile_v41_i(profile_v41_i), .telegram_i(telegram_i),
    .turns_sel_i(turns_sel_i), .op_status_i(op_status_i), .faults_i(faults_i),
    .xist1_offset_i(xist1_offset_i), .units_per_rev_i(units_per_rev_i),
    .total_range_i(total_range_i), .velocity_unit_i(velocity_unit_i),
    .sensor_control_word_i(sensor_control_word_i), .nv_store_done_i(nv_store_done_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .lifesign_limit_o(lifesign_limit_o),
    .lifesign_monitor_en_o(lifesign_monitor_en_o), .nv_store_req_o(nv_store_req_o),
    .preset_value_o(preset_value_o), .preset_apply_o(preset_apply_o));

  ctrl_model #(.SAVE_CYCLES(6)) CTRL (.sys_clk_i(sys_clk_i), .rsp_valid_i(rsp_valid_o),
    .rsp_i(rsp_o), .nv_store_req_i(nv_store_req_o), .req_valid_o(req_valid_i),
    .req_o(req_i), .nv_store_done_o(nv_store_done_i));

  // one comparison; four-state so an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, answer checked for strobe, error flag and data
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
    input logic [15:0] md, input logic [31:0] wd, input logic e, input logic [31:0] exp);
    logic v;
    param_rsp_t a;
    CTRL.xfer('{w, idx, sub, md, wd}, v, a);
    check({31'h0, v}, 32'h1);
    check({31'h0, a.err}, {31'h0, e});
    check(a.data, exp);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    acc(1'b0, idx, sub, 16'h0, 32'h0, 1'b0, exp);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd, input logic e);
    acc(1'b1, idx, 8'h0, 16'h0, wd, e, 32'h0);
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // 50 MHz system clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    #(20 * 20000);
    n_errors++;
    complete_run();
  end

  initial
  begin
    n_errors = 0;
    n_compared = 0;
    rst_i = 1'b1;
    compat_mode_i = 1'b0;
    profile_v41_i = 1'b0;
    telegram_i = 16'd81;
    turns_sel_i = 2'd0;
    op_status_i = 32'h0000_0022;
    faults_i = 32'h0000_00FF; // bits outside the supported mask read as zero
    xist1_offset_i = 32'h1234_5678;
    units_per_rev_i = 32'h0001_0000;
    total_range_i = 32'h0000_0064;
    velocity_unit_i = 32'h0000_0003;
    sensor_control_word_i = 16'h0000;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check({rsp_valid_o, nv_store_req_o, preset_apply_o, lifesign_monitor_en_o}, 32'h1);
    check({24'h0, lifesign_limit_o}, 32'h1);
    check(preset_value_o | rsp_o.data, 32'h0);
    $display("reset test done");
    // identification, capability and status tables, fixed and live entries
    foreach (dev_w[i]) rd(PAR_DEV_ID, 8'(i), dev_w[i]);
    foreach (do_w[i]) rd(PAR_DO_ID, 8'(i), do_w[i]);
    foreach (acc_w[i]) rd(PAR_ACCESS, 8'(i), acc_w[i]);
    foreach (sens_w[i]) rd(PAR_SENSOR, 8'(i), sens_w[i]);
    foreach (list_w[i]) rd(PAR_LIST, 8'(i), {16'h0, list_w[i]});
    foreach (ops_w[i]) rd(PAR_OPSTAT, 8'(i), ops_w[i]);
    rd(PAR_PROF_ID, 8'h0, 32'h3D);
    rd(PAR_PROF_ID, 8'h1, 32'd31);
    profile_v41_i <= 1'b1;
    rd(PAR_PROF_ID, 8'h1, 32'd41);
    foreach (det_w[i])
    begin
      turns_sel_i <= 2'(i);
      rd(PAR_SENSOR, 8'h5, det_w[i]);
    end
    foreach (tg_w[i])
    begin
      telegram_i <= tg_w[i][15:0];
      rd(PAR_TELEGRAM, 8'h0, tg_w[i]);
    end
    // record words: first, second straddling two fields, last
    rd(PAR_IM_RECORD, 8'h0, IMH[47:16]);
    rd(PAR_IM_RECORD, 8'h1, {IMH[15:0], IMV[47:32]});
    rd(PAR_IM_RECORD, 8'hF, IMT[31:0]);
    $display("table test done");
    foreach (bad_w[i]) acc(bad_w[i][40], bad_w[i][39:24], bad_w[i][23:16], bad_w[i][15:0],
      32'h0, 1'b1, 32'h0);
    rd(PAR_TELEGRAM, 8'h0, 32'd860);
    $display("refusal test done");
    // tolerance: bounds, compat mode only, 255 stops monitoring
    compat_mode_i <= 1'b1;
    wr(PAR_LIFESIGN, 32'd0, 1'b1);
    wr(PAR_LIFESIGN, 32'd256, 1'b1);
    wr(PAR_LIFESIGN, 32'd254, 1'b0);
    rd(PAR_LIFESIGN, 8'h0, 32'd254);
    check({23'h0, lifesign_monitor_en_o, lifesign_limit_o}, 32'h1FE);
    wr(PAR_LIFESIGN, 32'd255, 1'b0);
    @(posedge sys_clk_i);
    #1;
    check({31'h0, lifesign_monitor_en_o}, 32'h0);
    compat_mode_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    check({23'h0, lifesign_monitor_en_o, lifesign_limit_o}, 32'h101);
    $display("tolerance test done");
    // store trigger: range, start, cleared by the memory
    wr(PAR_NV_STORE, 32'd2, 1'b1);
    check({31'h0, nv_store_req_o}, 32'h0);
    wr(PAR_NV_STORE, 32'd1, 1'b0);
    check({31'h0, nv_store_req_o}, 32'h1);
    rd(PAR_NV_STORE, 8'h0, 32'h1);
    cnt = 0;
    while (nv_store_req_o === 1'b1 && cnt < 50)
    begin
      @(posedge sys_clk_i);
      #1;
      cnt++;
    end
    check({31'h0, nv_store_req_o}, 32'h0);
    rd(PAR_NV_STORE, 8'h0, 32'h0);
    $display("store test done");
    // preset: range against the live total range, no apply on write
    wr(PAR_PRESET, 32'd100, 1'b1);
    check(preset_value_o, 32'h0);
    wr(PAR_PRESET, 32'd99, 1'b0);
    check({preset_apply_o, preset_value_o[30:0]}, 32'd99);
    rd(PAR_PRESET, 8'h0, 32'd99);
    @(posedge sys_clk_i);
    sensor_control_word_i <= 16'h1000;
    @(posedge sys_clk_i);
    #1;
    check({31'h0, preset_apply_o}, 32'h1);
    repeat (4)
    begin
      @(posedge sys_clk_i);
      #1;
      check({31'h0, preset_apply_o}, 32'h0);
    end
    $display("preset test done");
    complete_run();
  end
endmodule
